// File: dcad_decoder.sv
// DDR3 command, address and data-qualifier input logic of an eight-bank device.
// Assumes CK, CK#, strobes and pins arrive asynchronously and are oversampled by a much faster I_SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "dcad_defs.svh"

module dcad_decoder
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_CK,
	input wire logic I_CK_N,
	input wire dcad_pkg::dcad_pins_t I_PINS,
	input wire logic [15:0] I_DQ,
	input wire logic [1:0] I_DM,
	input wire logic [1:0] I_DQS,
	output logic O_CMD_VALID,
	output dcad_pkg::dcad_req_t O_CMD,
	output logic [`DCAD_BANKS-1:0] O_BANK_OPEN,
	output logic [`DCAD_ADDR_W-1:0] O_MODE_OP,
	output logic [1:0] O_DQS_O,
	output logic [1:0] O_DQS_N_O,
	output logic [1:0] O_DQS_OE_N,
	output logic [15:0] O_WR_DATA,
	output logic [1:0] O_WR_BYTE_EN,
	output logic [1:0] O_WR_STB
);

	//****************************************
	// Input synchronisers
	//****************************************
	dcad_pkg::dcad_pins_t pins_s1, pins_s2, pins_s3;
	logic [2:0] ck_s, ckn_s;
	logic ck_lvl;
	logic [1:0] dqs_s1, dqs_s2, dqs_s3, dqs_lvl;
	logic [15:0] dq_s1, dq_s2, dq_s3;
	logic [1:0] dm_s1, dm_s2, dm_s3;
	logic ck_edge;

	// Three stages everywhere so pins and clock share the same delay
	always_ff @(posedge I_SYS_CLK)
	begin
		{pins_s3, pins_s2, pins_s1} <= {pins_s2, pins_s1, I_PINS};
		ck_s <= {ck_s[1:0], I_CK};
		ckn_s <= {ckn_s[1:0], I_CK_N};
		{dqs_s3, dqs_s2, dqs_s1} <= {dqs_s2, dqs_s1, I_DQS};
		{dq_s3, dq_s2, dq_s1} <= {dq_s2, dq_s1, I_DQ};
		{dm_s3, dm_s2, dm_s1} <= {dm_s2, dm_s1, I_DM};
	end

	// Settled clock level; a change counts only when stages two and three agree
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			ck_lvl <= 1'b0;
		else if (ck_s[1] == ck_s[2])
			ck_lvl <= ck_s[2];
	end
	// Crossing point: CK settles high while CK# has settled low
	assign ck_edge = (ck_s[1] == ck_s[2]) && ck_s[2] && !ck_lvl && (ckn_s[1] == ckn_s[2]) && !ckn_s[2];

	//****************************************
	// Command decode
	//****************************************
	function automatic dcad_pkg::dcad_cmd_t decode(input dcad_pkg::dcad_pins_t p);
		if (p.cs_n)
			decode = dcad_pkg::DCAD_DESEL;
		else
			case ({p.ras_n, p.cas_n, p.we_n})
				3'h3: decode = dcad_pkg::DCAD_ACT;
				3'h2: decode = dcad_pkg::DCAD_PRE;
				3'h5: decode = dcad_pkg::DCAD_RD;
				3'h4: decode = dcad_pkg::DCAD_WR;
				3'h0: decode = dcad_pkg::DCAD_MRS;
				3'h7: decode = dcad_pkg::DCAD_NOP;
				default: decode = dcad_pkg::DCAD_OTHER;
			endcase
	endfunction : decode

	dcad_pkg::dcad_cmd_t cur_cmd;
	logic otf, chop_now;
	logic [`DCAD_BL_MSB-`DCAD_BL_LSB:0] bl_mode;
	assign cur_cmd = ck_edge ? decode(pins_s3) : dcad_pkg::DCAD_DESEL;
	assign bl_mode = O_MODE_OP[`DCAD_BL_MSB:`DCAD_BL_LSB];
	assign otf = (bl_mode == `DCAD_BL_OTF);
	// Fixed BC4 chops always; on-the-fly mode reads the chop bit, low meaning chop
	assign chop_now = otf ? !pins_s3.addr[`DCAD_BC_BIT] : (bl_mode == `DCAD_BL_FIXED4);

	// Registered command for the array; data fields are held until the next command other than deselect or no-operation
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			O_CMD_VALID <= 1'b0;
			O_CMD <= '0;
		end
		else
		begin
			O_CMD_VALID <= (cur_cmd != dcad_pkg::DCAD_DESEL) && (cur_cmd != dcad_pkg::DCAD_NOP);
			if (cur_cmd != dcad_pkg::DCAD_DESEL && cur_cmd != dcad_pkg::DCAD_NOP)
			begin
				O_CMD.cmd <= cur_cmd;
				O_CMD.bank <= pins_s3.ba;
				O_CMD.row <= pins_s3.addr;
				O_CMD.col <= pins_s3.addr[`DCAD_COL_W-1:0];
				O_CMD.auto_pre <= pins_s3.addr[`DCAD_AP_BIT];
				O_CMD.all_banks <= pins_s3.addr[`DCAD_AP_BIT];
				O_CMD.chop <= chop_now;
			end
		end
	end

	// Mode register load; only the register that holds the burst mode is kept here
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			O_MODE_OP <= `DCAD_MR0_RST;
		else if (cur_cmd == dcad_pkg::DCAD_MRS && pins_s3.ba == `DCAD_MR_SEL)
			O_MODE_OP <= pins_s3.addr;
	end

	//****************************************
	// Burst tracking and bank state
	//****************************************
	dcad_pkg::dcad_burst_t burst;
	logic [2:0] burst_left;
	logic burst_ap;
	logic [`DCAD_BA_W-1:0] burst_bank;
	logic burst_end;
	logic [`DCAD_BANKS-1:0] next_bank_open;
	logic [`DCAD_ADDR_W-1:0] open_row [`DCAD_BANKS];

	assign burst_end = ck_edge && (burst != dcad_pkg::DCAD_B_IDLE) && (burst_left == 3'h1);
	// A new access restarts the burst, so seamless back to back bursts are allowed
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			burst <= dcad_pkg::DCAD_B_IDLE;
			burst_left <= 3'h0;
			burst_ap <= 1'b0;
			burst_bank <= '0;
		end
		else if (cur_cmd == dcad_pkg::DCAD_RD || cur_cmd == dcad_pkg::DCAD_WR)
		begin
			burst <= (cur_cmd == dcad_pkg::DCAD_RD) ? dcad_pkg::DCAD_B_RD : dcad_pkg::DCAD_B_WR;
			burst_left <= chop_now ? `DCAD_BURST4_CK : `DCAD_BURST8_CK;
			burst_ap <= pins_s3.addr[`DCAD_AP_BIT];
			burst_bank <= pins_s3.ba;
		end
		else if (burst_end)
		begin
			burst <= dcad_pkg::DCAD_B_IDLE;
			burst_left <= 3'h0;
		end
		else if (ck_edge && burst != dcad_pkg::DCAD_B_IDLE)
			burst_left <= burst_left - 3'h1;
	end

	// Burst-end closing first, so a command in the same cycle has the final say
	always_comb
	begin
		next_bank_open = O_BANK_OPEN;
		if (burst_end && burst_ap)
			next_bank_open[burst_bank] = 1'b0;
		case (cur_cmd)
			dcad_pkg::DCAD_ACT: next_bank_open[pins_s3.ba] = 1'b1;
			dcad_pkg::DCAD_PRE:
			begin
				if (pins_s3.addr[`DCAD_AP_BIT])
					next_bank_open = '0;
				else
					next_bank_open[pins_s3.ba] = 1'b0;
			end
			default: ;
		endcase
	end
	// Bank state register; openings and closings land together on one edge
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			O_BANK_OPEN <= '0;
		else
			O_BANK_OPEN <= next_bank_open;
	end
	// Row kept per bank for the array; no reset needed on storage
	always_ff @(posedge I_SYS_CLK)
	begin
		if (cur_cmd == dcad_pkg::DCAD_ACT)
			open_row[pins_s3.ba] <= pins_s3.addr;
	end

	//****************************************
	// Data strobes and write capture
	//****************************************
	// Device drives both strobe pairs only during a read burst, toggling on each rising CK crossing
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST || burst != dcad_pkg::DCAD_B_RD)
			O_DQS_O <= 2'h0;
		else if (ck_edge)
			O_DQS_O <= ~O_DQS_O;
	end
	assign O_DQS_N_O = ~O_DQS_O;
	assign O_DQS_OE_N = (burst == dcad_pkg::DCAD_B_RD) ? 2'h0 : 2'h3;

	// Settled strobe level per lane
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
			dqs_lvl <= 2'h0;
		else
			dqs_lvl <= (dqs_s2 ~^ dqs_s3) & dqs_s3 | ~(dqs_s2 ~^ dqs_s3) & dqs_lvl;
	end

	// Each lane latches its own byte and mask on either strobe edge while writing
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RST)
		begin
			O_WR_DATA <= 16'h0000;
			O_WR_BYTE_EN <= 2'h0;
			O_WR_STB <= 2'h0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				O_WR_STB[i] <= 1'b0;
				if (burst == dcad_pkg::DCAD_B_WR && dqs_s2[i] == dqs_s3[i] && dqs_s3[i] != dqs_lvl[i])
				begin
					O_WR_DATA[i*8 +: 8] <= dq_s3[i*8 +: 8];
					O_WR_BYTE_EN[i] <= !dm_s3[i];
					O_WR_STB[i] <= 1'b1;
				end
			end
		end
	end

	//****************************************
	// Checks
	//****************************************
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	sequence s_cmd(logic [2:0] rcw);
		ck_edge && !pins_s3.cs_n && {pins_s3.ras_n, pins_s3.cas_n, pins_s3.we_n} == rcw;
	endsequence
	chk_deselect_masked: assert property (ck_edge && pins_s3.cs_n |=> !O_CMD_VALID)
		else $error("Command taken while chip select high");
	chk_act_opens_bank: assert property (s_cmd(3'h3) |=> O_BANK_OPEN[O_CMD.bank] && O_CMD.cmd == dcad_pkg::DCAD_ACT)
		else $error("Activate did not open the bank");
	chk_act_row_full: assert property (s_cmd(3'h3) |=> O_CMD.row == $past(pins_s3.addr))
		else $error("Row address not captured whole");
	chk_col_low_bits: assert property (s_cmd(3'h5) |=> O_CMD.col == $past(pins_s3.addr[9:0]))
		else $error("Column not taken from low bits");
	chk_pre_all_close: assert property (s_cmd(3'h2) and pins_s3.addr[10] |=> O_BANK_OPEN == 8'h00)
		else $error("Precharge all left a bank open");
	chk_pre_one_close: assert property (s_cmd(3'h2) and !pins_s3.addr[10]
		and !(burst_end && burst_ap) |=> !O_BANK_OPEN[O_CMD.bank] &&
		($past(O_BANK_OPEN) & ~O_BANK_OPEN & ~(8'h01 << O_CMD.bank)) == 8'h00)
		else $error("Single precharge closed the wrong banks");
	chk_nop_keeps_state: assert property (s_cmd(3'h7) and !burst_end |=> $stable(O_BANK_OPEN) && !O_CMD_VALID)
		else $error("No-operation changed bank state");
	chk_chop_length: assert property (s_cmd(3'h5) and otf and !pins_s3.addr[12] |=> burst_left == 3'h2)
		else $error("On-the-fly chop not applied");
	chk_mrs_loads_op: assert property (s_cmd(3'h0) and pins_s3.ba == 3'h0 |=> O_MODE_OP == $past(pins_s3.addr))
		else $error("Mode opcode not loaded");
	chk_read_drives_dqs: assert property (burst == dcad_pkg::DCAD_B_RD && ck_edge |=>
		O_DQS_O == ~$past(O_DQS_O) && O_DQS_N_O == ~O_DQS_O)
		else $error("Read strobes did not toggle as a pair");
	chk_mask_drops_byte: assert property (O_WR_STB[1] |-> O_WR_BYTE_EN[1] == !$past(dm_s3[1]))
		else $error("Upper mask not applied");

endmodule : dcad_decoder
`default_nettype wire

// File: dcad_defs.svh
// Constants of the DDR3 command and address decoder: field positions, counts and reset values.
// Assumes inclusion by bare name from the package and the decoder module.
`ifndef DCAD_DEFS_SVH
`define DCAD_DEFS_SVH

`define DCAD_BANKS 8
`define DCAD_BA_W 3
`define DCAD_ADDR_W 15
`define DCAD_COL_W 10
`define DCAD_AP_BIT 10
`define DCAD_BC_BIT 12
`define DCAD_BL_LSB 0
`define DCAD_BL_MSB 1
`define DCAD_BL_FIXED8 2'h0
`define DCAD_BL_OTF 2'h1
`define DCAD_BL_FIXED4 2'h2
`define DCAD_MR0_RST 15'h0000
`define DCAD_BURST8_CK 3'h4
`define DCAD_BURST4_CK 3'h2
`define DCAD_MR_SEL 3'h0

`endif

// File: dcad_pkg.sv
// Types shared by the DDR3 command and address decoder.
// Assumes dcad_defs.svh is on the include path.
`include "dcad_defs.svh"

package dcad_pkg;

	// Decoded command codes
	typedef enum logic [2:0]
	{
		DCAD_DESEL = 3'h0,
		DCAD_NOP = 3'h1,
		DCAD_ACT = 3'h2,
		DCAD_PRE = 3'h3,
		DCAD_RD = 3'h4,
		DCAD_WR = 3'h5,
		DCAD_MRS = 3'h6,
		DCAD_OTHER = 3'h7
	} dcad_cmd_t;

	// Command and address pins as sampled
	typedef struct packed
	{
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [`DCAD_BA_W-1:0] ba;
		logic [`DCAD_ADDR_W-1:0] addr;
	} dcad_pins_t;

	// One decoded command for the array logic
	typedef struct packed
	{
		dcad_cmd_t cmd;
		logic [`DCAD_BA_W-1:0] bank;
		logic [`DCAD_ADDR_W-1:0] row;
		logic [`DCAD_COL_W-1:0] col;
		logic auto_pre;
		logic all_banks;
		logic chop;
	} dcad_req_t;

	// Burst tracking states
	typedef enum logic [1:0]
	{
		DCAD_B_IDLE = 2'h0,
		DCAD_B_RD = 2'h1,
		DCAD_B_WR = 2'h3
	} dcad_burst_t;

endpackage : dcad_pkg

// File: dcad_ctrl_model.sv
// Memory controller model driving the DDR clock pair, command pins and write data lanes.
// Assumes a free-running system clock; each call of ck_cycle is one DDR clock period of 16 system clocks.
`timescale 1ns/10ps
`default_nettype none

module dcad_ctrl_model
(
	input wire logic i_clk,
	output logic o_ck,
	output logic o_ck_n,
	output dcad_pkg::dcad_pins_t o_pins,
	output logic [15:0] o_dq,
	output logic [1:0] o_dm,
	output logic [1:0] o_dqs
);
	// Idle levels: clock low, chip deselected
	initial
	begin
		o_ck = 1'h0;
		o_ck_n = 1'h1;
		o_pins = 22'h3FFFFF;
		o_dq = 16'h0000;
		o_dm = 2'h0;
		o_dqs = 2'h0;
	end

	// Inputs move one step after the system edge so no race with sampling
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wait_clk

	// One DDR period; the clock stands low between calls
	task automatic ck_cycle(input logic [3:0] cmd, input logic [2:0] ba, input logic [14:0] addr,
		input logic [1:0] tgl, input logic [15:0] dq, input logic [1:0] dm);
		o_pins = {cmd, ba, addr};
		wait_clk(8);
		o_ck = 1'h1;
		o_ck_n = 1'h0;
		wait_clk(2);
		// Released pins show the inverse, with chip select held high, so stale values cannot pass
		o_pins = {1'h1, ~cmd[2:0], ~ba, ~addr};
		o_dq = dq;
		o_dm = dm;
		wait_clk(1);
		// Strobe edge early in the period so its capture pulse is out before the call returns
		o_dqs = o_dqs ^ tgl;
		wait_clk(5);
		o_dq = ~dq;
		o_dm = ~dm;
		o_ck = 1'h0;
		o_ck_n = 1'h1;
	endtask : ck_cycle
endmodule : dcad_ctrl_model
`default_nettype wire

// File: ddr3_command_address_decode_tb.sv
// Self-checking bench of the DDR3 command and address decoder.
// Assumes dcad_pkg and dcad_ctrl_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module ddr3_command_address_decode_tb;
	localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4, MRS = 4'h0, NOP = 4'h7, DES = 4'hB;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ck, ck_n;
	dcad_pkg::dcad_pins_t pins;
	logic [15:0] dq;
	logic [1:0] dm, dqs, dqs_o, dqs_n_o, dqs_oe_n, wr_en, wr_stb;
	logic valid;
	dcad_pkg::dcad_req_t req;
	logic [7:0] open_b;
	logic [14:0] mode_op;
	logic [15:0] wr_data;
	int fail_count = 0;
	int total_checks = 0;
	int valid_count = 0;
	int stb_count = 0;

	// ****************************************
	// Clock, parts and monitors
	// ****************************************
	always #5 clk = ~clk;

	dcad_ctrl_model CTRL (.i_clk(clk), .o_ck(ck), .o_ck_n(ck_n), .o_pins(pins), .o_dq(dq), .o_dm(dm), .o_dqs(dqs));

	dcad_decoder DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_CK(ck), .I_CK_N(ck_n), .I_PINS(pins), .I_DQ(dq),
		.I_DM(dm), .I_DQS(dqs), .O_CMD_VALID(valid), .O_CMD(req), .O_BANK_OPEN(open_b), .O_MODE_OP(mode_op),
		.O_DQS_O(dqs_o), .O_DQS_N_O(dqs_n_o), .O_DQS_OE_N(dqs_oe_n), .O_WR_DATA(wr_data),
		.O_WR_BYTE_EN(wr_en), .O_WR_STB(wr_stb));

	// Pulses are counted so one-cycle outputs are never missed
	always @(posedge clk)
	begin
		valid_count <= valid_count + int'(valid === 1'h1);
		stb_count <= stb_count + int'(wr_stb[0] === 1'h1) + int'(wr_stb[1] === 1'h1);
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'h1)
		begin
			fail_count++;
			$display("BAD at %0t: %s", $time, msg);
		end
	endtask : check

	// Sends one command and judges whether it raised a valid pulse
	task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [14:0] a, input int pulses);
		int n;
		n = valid_count;
		CTRL.ck_cycle(c, ba, a, 2'h0, 16'h0000, 2'h0);
		check(valid_count == n + pulses, "valid pulse count");
	endtask : cmd

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_act();
		cmd(MRS, 3'h0, 15'h0001, 1);
		check(mode_op === 15'h0001, "mode opcode");
		cmd(ACT, 3'h5, 15'h7ABC, 1);
		check(req.cmd === dcad_pkg::DCAD_ACT && req.bank === 3'h5, "act decode");
		check(req.row === 15'h7ABC && open_b === 8'h20, "act row");
		cmd(DES, 3'h2, 15'h0000, 0);
		cmd(NOP, 3'h2, 15'h0000, 0);
		check(open_b === 8'h20 && req.bank === 3'h5, "ignored cycles");
		$display("test_act done");
	endtask : test_act

	task automatic test_rd();
		cmd(RD, 3'h5, 15'h2BCD, 1);
		check(req.cmd === dcad_pkg::DCAD_RD && req.col === 10'h3CD, "read column");
		check(req.chop === 1'h1 && req.auto_pre === 1'h0, "read chop");
		check(dqs_oe_n === 2'h0 && dqs_n_o === ~dqs_o, "read strobes");
		cmd(NOP, 3'h0, 15'h0000, 0);
		check(dqs_oe_n === 2'h0 && dqs_o === 2'h3 && dqs_n_o === 2'h0, "read strobes toggle");
		cmd(NOP, 3'h0, 15'h0000, 0);
		check(dqs_oe_n === 2'h3 && open_b === 8'h20, "chopped end, row open");
		cmd(RD, 3'h5, 15'h1401, 1);
		check(req.chop === 1'h0 && req.auto_pre === 1'h1 && req.col === 10'h001, "read ap");
		cmd(NOP, 3'h0, 15'h0000, 0);
		cmd(NOP, 3'h0, 15'h0000, 0);
		cmd(NOP, 3'h0, 15'h0000, 0);
		check(dqs_oe_n === 2'h0 && open_b === 8'h20, "full burst runs");
		cmd(NOP, 3'h0, 15'h0000, 0);
		check(dqs_oe_n === 2'h3 && open_b === 8'h00, "auto precharge");
		$display("test_rd done");
	endtask : test_rd

	task automatic test_wr();
		int n;
		cmd(ACT, 3'h2, 15'h0010, 1);
		cmd(WR, 3'h2, 15'h1000, 1);
		check(req.cmd === dcad_pkg::DCAD_WR && req.bank === 3'h2, "write decode");
		n = stb_count;
		CTRL.ck_cycle(NOP, 3'h0, 15'h0000, 2'h3, 16'hA55A, 2'h2);
		check(stb_count == n + 2 && wr_data === 16'hA55A && wr_en === 2'h1, "masked lanes");
		CTRL.ck_cycle(NOP, 3'h0, 15'h0000, 2'h1, 16'h1234, 2'h0);
		check(wr_data === 16'hA534 && wr_en[0] === 1'h1, "lower lane only");
		cmd(NOP, 3'h0, 15'h0000, 0);
		cmd(NOP, 3'h0, 15'h0000, 0);
		n = stb_count;
		CTRL.ck_cycle(NOP, 3'h0, 15'h0000, 2'h3, 16'hFFFF, 2'h0);
		check(stb_count == n, "strobe outside burst");
		$display("test_wr done");
	endtask : test_wr

	task automatic test_pre();
		cmd(ACT, 3'h1, 15'h0000, 1);
		cmd(ACT, 3'h3, 15'h0000, 1);
		check(open_b === 8'h0E, "three open");
		cmd(PRE, 3'h1, 15'h0000, 1);
		check(req.cmd === dcad_pkg::DCAD_PRE && open_b === 8'h0C, "single precharge");
		cmd(PRE, 3'h3, 15'h0400, 1);
		check(req.all_banks === 1'h1 && open_b === 8'h00, "all precharge");
		$display("test_pre done");
	endtask : test_pre

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		check(dqs_oe_n === 2'h3 && open_b === 8'h00 && valid === 1'h0, "reset values");
		rst = 1'h0;
		CTRL.wait_clk(4);
		test_act();
		test_rd();
		test_wr();
		test_pre();
		stop_test();
	end

	// The run needs about 4 us; a hang is cut off well beyond that
	initial
	begin
		#50000;
		fail_count++;
		$display("BAD at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule : ddr3_command_address_decode_tb
`default_nettype wire
